// >>> asd_consts.svh
// address decoder constants: map boundaries, fill values, vector addresses
// assumes inclusion by the decoder package and module only
`ifndef ASD_CONSTS_SVH
`define ASD_CONSTS_SVH
`define ASD_RF_AW 12
`define ASD_PM_AW 16
`define ASD_CTRL_SLOTS 256
`define ASD_CTRL_IDX_W 8
`define ASD_RF_CTRL_BASE 12'hF00
`define ASD_RF_RAM_BASE 12'h000
`define ASD_RF_RAM_DEF 13'h0800
`define ASD_PM_FLASH_DEF 17'h0_4000
`define ASD_PM_FILL 8'hFF
`define ASD_RF_HOLE_FILL 8'h00
`define ASD_VEC_OPT 16'h0000
`define ASD_VEC_RESET 16'h0002
`define ASD_VEC_WATCHDOG 16'h0004
`define ASD_VEC_TRAP 16'h0006
`define ASD_VEC_IRQ_LO 16'h0008
`define ASD_VEC_IRQ_HI 16'h0037
`define ASD_CODE_BASE 16'h0038
`endif

// >>> asd_decoder.sv
// address space decoder: register file and program memory steering
// assumes the core holds address, strobes and write data steady one cycle
// assumes flash covers the vector area and ram sits below the control block
`timescale 1ns/1ps
`include "asd_consts.svh"
module asd_decoder #(
	parameter logic [12:0] RAM_BYTES = `ASD_RF_RAM_DEF,
	parameter logic [16:0] FLASH_BYTES = `ASD_PM_FLASH_DEF,
	parameter logic [`ASD_CTRL_SLOTS-1:0] CTRL_PRESENT =
		{`ASD_CTRL_SLOTS{1'b1}}
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// register file request from core
	input wire logic rf_req,
	input wire logic rf_we,
	input wire logic [`ASD_RF_AW-1:0] rf_addr,
	// register file targets
	output asd_pkg::asd_rf_region_t rf_region,
	output logic ram_sel,
	output logic ram_we,
	output logic ctrl_sel,
	output logic ctrl_we,
	input wire logic [7:0] ram_rdata,
	input wire logic [7:0] ctrl_rdata,
	output logic [7:0] rf_rdata,
	// program memory request from core
	input wire logic pm_req,
	input wire logic pm_we,
	input wire logic [`ASD_PM_AW-1:0] pm_addr,
	// program memory targets
	output asd_pkg::asd_pm_slot_t pm_slot,
	output logic flash_sel,
	output logic flash_we,
	input wire logic [7:0] flash_rdata,
	output logic [7:0] pm_rdata
);
	import asd_pkg::*;

	// fitted-size tests, shared by the decode and the checks below
	function automatic logic ram_fitted(input logic [`ASD_RF_AW-1:0] a);
		ram_fitted = {1'b0, a} < RAM_BYTES;
	endfunction : ram_fitted

	function automatic logic flash_fitted(input logic [`ASD_PM_AW-1:0] a);
		flash_fitted = {1'b0, a} < FLASH_BYTES;
	endfunction : flash_fitted

	function automatic asd_rf_region_t rf_class(
		input logic [`ASD_RF_AW-1:0] a);
		if (a >= `ASD_RF_CTRL_BASE) begin
			rf_class = CTRL_PRESENT[a[`ASD_CTRL_IDX_W-1:0]] ? ASD_RF_CTRL
				: ASD_RF_RSVD;
		end else if (ram_fitted(a)) begin
			rf_class = ASD_RF_RAM;
		end else begin
			rf_class = ASD_RF_UNIMP;
		end
	endfunction : rf_class

	function automatic asd_pm_slot_t pm_class(
		input logic [`ASD_PM_AW-1:0] a);
		if (!flash_fitted(a)) pm_class = ASD_PM_UNIMP;
		else if (a < `ASD_VEC_RESET) pm_class = ASD_PM_OPTION;
		else if (a < `ASD_VEC_WATCHDOG) pm_class = ASD_PM_RESET_VEC;
		else if (a < `ASD_VEC_TRAP) pm_class = ASD_PM_WATCHDOG_VEC;
		else if (a < `ASD_VEC_IRQ_LO) pm_class = ASD_PM_TRAP_VEC;
		else if (a < `ASD_CODE_BASE) pm_class = ASD_PM_IRQ_VEC;
		else pm_class = ASD_PM_CODE;
	endfunction : pm_class

	typedef struct packed {
		logic rf_rd_ram;
		logic rf_rd_ctrl;
		logic rf_rd_pend;
		logic pm_rd_flash;
		logic pm_rd_pend;
	} asd_state_t;

	asd_state_t st_reg;
	asd_state_t st_next;
	asd_rf_region_t rf_cls;
	asd_pm_slot_t pm_cls;

	// combinational decode so targets see selects in the request cycle
	assign rf_cls = rf_class(rf_addr);
	assign pm_cls = pm_class(pm_addr);
	assign rf_region = rf_cls;
	assign pm_slot = pm_cls;
	assign ram_sel = rf_req && rf_cls == ASD_RF_RAM;
	assign ram_we = ram_sel && rf_we;
	// reserved writes still reach the block; core must avoid them
	assign ctrl_sel = rf_req && (rf_cls == ASD_RF_CTRL
		|| rf_cls == ASD_RF_RSVD);
	assign ctrl_we = ctrl_sel && rf_we;
	assign flash_sel = pm_req && pm_cls != ASD_PM_UNIMP;
	assign flash_we = flash_sel && pm_we;

	// region decodes are captured every cycle; the pend bits decide if they count
	always_comb begin
		st_next = st_reg;
		st_next.rf_rd_pend = rf_req && !rf_we;
		st_next.rf_rd_ram = rf_cls == ASD_RF_RAM;
		st_next.rf_rd_ctrl = rf_cls == ASD_RF_CTRL;
		st_next.pm_rd_pend = pm_req && !pm_we;
		st_next.pm_rd_flash = pm_cls != ASD_PM_UNIMP;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// read data one cycle after the request; holes give a fixed fill
	// idle cycles show the fill too, so a stale target byte never leaks
	always_comb begin
		rf_rdata = `ASD_RF_HOLE_FILL;
		pm_rdata = `ASD_PM_FILL;
		if (st_reg.rf_rd_pend && st_reg.rf_rd_ram) begin
			rf_rdata = ram_rdata;
		end else if (st_reg.rf_rd_pend && st_reg.rf_rd_ctrl) begin
			rf_rdata = ctrl_rdata;
		end
		if (st_reg.pm_rd_pend && st_reg.pm_rd_flash) begin
			pm_rdata = flash_rdata;
		end
	end

	// checks share one clock and one reset, so they take the defaults
	default clocking asd_cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	// register file steering and read data
	a_ctrl_top_route: assert property (
		rf_req && rf_addr >= `ASD_RF_CTRL_BASE |-> !ram_sel)
		else $error("control address reached ram");
	a_rf_space_sel: assert property (
		rf_req |-> $onehot0({ram_sel, ctrl_sel}))
		else $error("two register targets selected");
	a_ram_low_sel: assert property (
		rf_req && ram_fitted(rf_addr) && rf_addr < `ASD_RF_CTRL_BASE
		|-> ram_sel)
		else $error("fitted ram not selected");
	a_hole_write_drop: assert property (
		rf_cls == ASD_RF_UNIMP |-> !ram_we && !ctrl_we)
		else $error("hole write reached a target");
	a_hole_no_select: assert property (
		!ram_fitted(rf_addr) && rf_addr < `ASD_RF_CTRL_BASE
		|-> !ram_sel && !ctrl_sel)
		else $error("hole address selected a target");
	a_rf_one_cycle: assert property (
		rf_req && !rf_we && rf_cls == ASD_RF_UNIMP
		|=> rf_rdata == `ASD_RF_HOLE_FILL)
		else $error("hole read not answered next cycle");
	a_rsvd_no_ram: assert property (
		rf_cls == ASD_RF_RSVD |-> !ram_sel)
		else $error("reserved location hit ram");
	a_rsvd_read_fill: assert property (
		rf_req && !rf_we && rf_addr >= `ASD_RF_CTRL_BASE
		&& !CTRL_PRESENT[rf_addr[`ASD_CTRL_IDX_W-1:0]]
		|=> rf_rdata == `ASD_RF_HOLE_FILL)
		else $error("reserved read not filled");
	a_ctrl_read_pass: assert property (
		rf_req && !rf_we && rf_addr >= `ASD_RF_CTRL_BASE
		&& CTRL_PRESENT[rf_addr[`ASD_CTRL_IDX_W-1:0]]
		|=> rf_rdata == ctrl_rdata)
		else $error("control read data not passed");
	a_ram_read_pass: assert property (
		rf_req && !rf_we && ram_sel |=> rf_rdata == ram_rdata)
		else $error("ram read data not passed");

	// program memory steering and read data
	a_pm_fill_read: assert property (
		pm_req && !pm_we && !flash_fitted(pm_addr)
		|=> pm_rdata == `ASD_PM_FILL)
		else $error("unfitted flash read not FFH");
	a_pm_write_drop: assert property (
		!flash_fitted(pm_addr) |-> !flash_we && !flash_sel)
		else $error("unfitted flash write passed");
	a_flash_range: assert property (
		pm_req && flash_fitted(pm_addr) |-> flash_sel)
		else $error("fitted flash not selected");
	a_flash_read_pass: assert property (
		pm_req && !pm_we && flash_fitted(pm_addr)
		|=> pm_rdata == flash_rdata)
		else $error("flash read data not passed");

	// fixed slots at the bottom of fitted flash and the code slot above them
	a_option_slot: assert property (
		pm_addr < `ASD_VEC_RESET && flash_fitted(pm_addr)
		|-> pm_slot == ASD_PM_OPTION)
		else $error("option slot wrong");
	a_reset_slot: assert property (
		pm_addr >= `ASD_VEC_RESET && pm_addr < `ASD_VEC_WATCHDOG
		&& flash_fitted(pm_addr) |-> pm_slot == ASD_PM_RESET_VEC)
		else $error("reset vector slot wrong");
	a_vector_slot: assert property (
		pm_addr >= `ASD_VEC_WATCHDOG && pm_addr < `ASD_VEC_TRAP
		&& flash_fitted(pm_addr) |-> pm_slot == ASD_PM_WATCHDOG_VEC)
		else $error("watchdog vector slot wrong");
	a_trap_slot: assert property (
		pm_addr >= `ASD_VEC_TRAP && pm_addr < `ASD_VEC_IRQ_LO
		&& flash_fitted(pm_addr) |-> pm_slot == ASD_PM_TRAP_VEC)
		else $error("trap vector slot wrong");
	a_irq_slot: assert property (
		pm_addr >= `ASD_VEC_IRQ_LO && pm_addr <= `ASD_VEC_IRQ_HI
		&& flash_fitted(pm_addr) |-> pm_slot == ASD_PM_IRQ_VEC)
		else $error("interrupt vector slot wrong");
	a_code_slot: assert property (
		pm_addr >= `ASD_CODE_BASE && flash_fitted(pm_addr)
		|-> pm_slot == ASD_PM_CODE)
		else $error("code slot wrong");

	// main access kinds worth seeing at least once
	c_ram_read: cover property (rf_req && !rf_we && ram_sel);
	c_ctrl_write: cover property (ctrl_we);
	c_hole_read: cover property (
		rf_req && !rf_we && rf_cls == ASD_RF_UNIMP);
	c_pm_unimp_read: cover property (
		pm_req && !pm_we && pm_cls == ASD_PM_UNIMP);
	c_reset_vec: cover property (pm_req && pm_cls == ASD_PM_RESET_VEC);
endmodule : asd_decoder

// >>> asd_decoder_tb_top.sv
// self-checking bench for the address space decoder
// assumes default ram and flash sizes; control slot 48 left unfitted
`timescale 1ns/1ps
module asd_decoder_tb_top;
	localparam logic [255:0] CM = ~(256'h1 << 8'h30);
	logic core_clk = 1'b0, rst_b = 1'b0, rf_req = 1'b0, rf_we = 1'b0;
	logic pm_req = 1'b0, pm_we = 1'b0;
	logic [11:0] rf_addr = 12'h000;
	logic [15:0] pm_addr = 16'h0000;
	logic [7:0] rf_rdata, pm_rdata, ram_rdata, ctrl_rdata, flash_rdata;
	logic [7:0] rq[$], pq[$];
	logic ram_sel, ram_we, ctrl_sel, ctrl_we, flash_sel, flash_we;
	asd_pkg::asd_rf_region_t rf_region;
	asd_pkg::asd_pm_slot_t pm_slot;
	int mismatches = 0, cmp_count = 0, i;
	integer seed = 92149;
	logic [11:0] rt[7] = '{12'h000, 12'h7ff, 12'h800, 12'heff, 12'hf00,
		12'hf30, 12'hfff};
	logic [15:0] pt[10] = '{16'h0000, 16'h0002, 16'h0004, 16'h0006,
		16'h0008, 16'h0037, 16'h0038, 16'h3fff, 16'h4000, 16'hffff};
	wire logic [7:0] sels = {ram_sel, ram_we, ctrl_sel, ctrl_we, flash_sel,
		flash_we, 2'h0};
	asd_decoder #(.CTRL_PRESENT(CM)) DUT (.core_clk(core_clk), .rst_b(rst_b),
		.rf_req(rf_req), .rf_we(rf_we), .rf_addr(rf_addr),
		.rf_region(rf_region), .ram_sel(ram_sel), .ram_we(ram_we),
		.ctrl_sel(ctrl_sel), .ctrl_we(ctrl_we), .ram_rdata(ram_rdata),
		.ctrl_rdata(ctrl_rdata), .rf_rdata(rf_rdata), .pm_req(pm_req),
		.pm_we(pm_we), .pm_addr(pm_addr), .pm_slot(pm_slot),
		.flash_sel(flash_sel), .flash_we(flash_we),
		.flash_rdata(flash_rdata), .pm_rdata(pm_rdata));
	asd_mem_model u_mem (.core_clk(core_clk), .ram_sel(ram_sel),
		.ram_we(ram_we), .ctrl_sel(ctrl_sel), .ctrl_we(ctrl_we),
		.flash_sel(flash_sel), .flash_we(flash_we), .rf_addr(rf_addr),
		.pm_addr(pm_addr), .ram_rdata(ram_rdata), .ctrl_rdata(ctrl_rdata),
		.flash_rdata(flash_rdata));
	initial forever #25 core_clk = ~core_clk;
	function automatic int rf_cls(int a);
		if (a >= 12'hf00) return CM[a - 12'hf00] ? 1 : 2;
		return a < 12'h800 ? 0 : 3;
	endfunction : rf_cls
	function automatic int pm_cls(int p);
		if (p >= 16'h4000) return 6;
		if (p < 8) return p / 2;
		return p < 16'h0038 ? 4 : 5;
	endfunction : pm_cls
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic step(input logic [11:0] a, input logic [15:0] p,
		input logic [3:0] c);
		int r, q;
		logic s, t, f;
		r = rf_cls(a);
		q = pm_cls(p);
		if (r == 2) c[2] = 1'b0;
		@(posedge core_clk);
		rf_addr <= a;
		pm_addr <= p;
		{rf_req, rf_we, pm_req, pm_we} <= c;
		@(negedge core_clk);
		if (rq.size() > 0) chk(rf_rdata, rq.pop_front());
		if (pq.size() > 0) chk(pm_rdata, pq.pop_front());
		chk({6'h0, rf_region}, 8'(r));
		chk({5'h0, pm_slot}, 8'(q));
		s = c[3] && r == 0;
		t = c[3] && r inside {1, 2};
		f = c[1] && q < 6;
		chk(sels, {s, s && c[2], t, t && c[2], f, f && c[0],
			2'h0});
		if (c[3] && !c[2])
			rq.push_back(r == 0 ? a[7:0] ^ 8'h5a :
				r == 1 ? a[7:0] ^ 8'hc3 : 8'h00);
		if (c[1] && !c[0])
			pq.push_back(q < 6 ? p[7:0] ^ p[15:8] : 8'hff);
	endtask : step
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results
	initial begin
		repeat (5000) @(posedge core_clk);
		mismatches++;
		results();
	end
	initial begin
		repeat (10) @(posedge core_clk);
		chk(rf_rdata, 8'h00);
		chk(pm_rdata, 8'hff);
		rst_b <= 1'b1;
		for (i = 0; i < 20; i++) step(rt[i % 7], pt[i % 10], {1'b1, i[0], 1'b1,
			i >= 10});
		$display("boundary test done");
		@(posedge core_clk);
		rst_b <= 1'b0;
		{rf_req, pm_req} <= 2'h0;
		repeat (2) @(posedge core_clk);
		chk(rf_rdata, 8'h00);
		chk(pm_rdata, 8'hff);
		chk(sels, 8'h00);
		rq.delete();
		pq.delete();
		rst_b <= 1'b1;
		$display("mid-run reset test done");
		for (i = 0; i < 600; i++) step(12'($random(seed)), 16'($random(seed)),
			4'($random(seed)));
		step(12'h000, 16'h0000, 4'h0);
		$display("random test done");
		results();
	end
endmodule : asd_decoder_tb_top

// >>> asd_mem_model.sv
// far-side targets: ram, control block and flash read ports
// assumes decoder selects; read data is due one cycle after select
`timescale 1ns/1ps
module asd_mem_model (
	// clock
	input wire logic core_clk,
	// requests from decoder
	input wire logic ram_sel,
	input wire logic ram_we,
	input wire logic ctrl_sel,
	input wire logic ctrl_we,
	input wire logic flash_sel,
	input wire logic flash_we,
	input wire logic [11:0] rf_addr,
	input wire logic [15:0] pm_addr,
	// read data
	output logic [7:0] ram_rdata = 8'h00,
	output logic [7:0] ctrl_rdata = 8'h00,
	output logic [7:0] flash_rdata = 8'h00
);
	// idle data churns so a stale byte never passes for a hit
	always @(posedge core_clk) begin
		ram_rdata <= (ram_sel && !ram_we) ? rf_addr[7:0] ^ 8'h5a : ~ram_rdata;
		ctrl_rdata <= (ctrl_sel && !ctrl_we) ? rf_addr[7:0] ^ 8'hc3 :
			~ctrl_rdata;
		flash_rdata <= (flash_sel && !flash_we) ?
			pm_addr[7:0] ^ pm_addr[15:8] : ~flash_rdata;
	end
endmodule : asd_mem_model

// >>> asd_pkg.sv
// address decoder types: register file regions, program memory slots
// assumes the constants header sits in the same folder
`include "asd_consts.svh"
package asd_pkg;
	typedef enum logic [1:0] {
		ASD_RF_RAM,
		ASD_RF_CTRL,
		ASD_RF_RSVD,
		ASD_RF_UNIMP
	} asd_rf_region_t;
	typedef enum logic [2:0] {
		ASD_PM_OPTION,
		ASD_PM_RESET_VEC,
		ASD_PM_WATCHDOG_VEC,
		ASD_PM_TRAP_VEC,
		ASD_PM_IRQ_VEC,
		ASD_PM_CODE,
		ASD_PM_UNIMP
	} asd_pm_slot_t;
endpackage : asd_pkg
